// File: common/rtc_map.svh
// Register offsets, field positions, reset values and counts for the clock core.
// Included by the logic and verification files; holds definitions only.
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH
`define CFG_OFS 5'h00
`define TWIN_OFS 5'h04
`define ACFG_OFS 5'h08
`define AWIN_OFS 5'h0C
`define KEY_OFS 5'h10
`define SRC_OFS 5'h14
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'hAA
`define ALRM_PTR_HI 9
`define ALRM_PTR_LO 8
`define SRC_TIMER_BIT 0
`define SRC_SECONDS_BIT 1
`define PTR_MS 2'h0
`define PTR_WH 2'h1
`define PTR_MD 2'h2
`define PTR_Y 2'h3
`define HALF_LAST 16'h3FFF
`define SYNC_LEAD 16'h0020
`define BCD_NINE 4'h9
`define ZERO_BCD 8'h00
`define ONE_BCD 8'h01
`define SEC_MAX 8'h59
`define MIN_MAX 8'h59
`define HOUR_MAX 8'h23
`define WDAY_MAX 8'h06
`define MONTH_MAX 8'h12
`define YEAR_MAX 8'h99
`define DAY_31 8'h31
`define DAY_30 8'h30
`define DAY_29 8'h29
`define DAY_28 8'h28
`define MON_FEB 8'h02
`define MON_APR 8'h04
`define MON_JUN 8'h06
`define MON_SEP 8'h09
`define MON_NOV 8'h11
`define RST_WDAY 8'h06
`define RST_ALARM_SETUP 16'h0000
`endif

// File: common/rtc_pkg.sv
// Types shared by the clock core files.
// Field order of cfg_view_t is the configuration register layout; bus_req_t packs the bus request.
package rtc_pkg;
  typedef struct packed {
    logic module_on;
    logic rsvd;
    logic time_write_unlock;
    logic ripple_warning;
    logic second_half_flag;
    logic tick_output_on;
    logic [1:0] time_window_pointer;
    logic [7:0] trim;
  } cfg_view_t;
  typedef struct packed {
    logic [4:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } bus_req_t;
  typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_FIRST, KEY_OPEN} key_state_t;
endpackage

// File: logic/bcd_unit.sv
// One two-digit BCD count stage with load, wrap and carry.
// Assumes a valid BCD load value; reset is power-on only.
`timescale 1ns/1ps
`include "rtc_map.svh"
module bcd_unit #(
  parameter logic [7:0] MIN_VAL = `ZERO_BCD,
  parameter logic [7:0] RST_VAL = `ZERO_BCD
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // Control
  input wire logic i_step,
  input wire logic i_load,
  input wire logic [7:0] i_load_val,
  input wire logic [7:0] i_max,
  // State
  output logic [7:0] o_value,
  output logic o_wrap
);
  wire logic [7:0] inc_val;
  assign inc_val = (o_value[3:0] >= `BCD_NINE) ?
                   {o_value[7:4] + 4'h1, 4'h0} : {o_value[7:4], o_value[3:0] + 4'h1};
  assign o_wrap = i_step & (o_value >= i_max);
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_value <= RST_VAL;
    end else if (i_load) begin
      o_value <= i_load_val;
    end else if (o_wrap) begin
      o_value <= MIN_VAL;
    end else if (i_step) begin
      o_value <= inc_val;
    end
  end
endmodule

// File: logic/rtc_calendar_core.sv
// Real-time clock and calendar core with an Avalon-MM register slave.
// Assumes i_sys_rst is power-on reset and i_pin_rst the external pin reset.
// Notes on behaviour
// - Count half-seconds, seconds, minutes and hours
// - Hours run in 24-hour form
// - Weekday and leap years done in hardware
// - All time values held as BCD
// - Output pin carries alarm or seconds tick
// - Time base from oscillator or timer pin
// - Counting survives external pin reset
// - Time pointer selects the value pair
// - High-byte write decrements pointer, stops at 00
// - Alarm pointer selects the alarm pair
// - Alarm high-byte write decrements, stops at 00
// - Any window read decrements its pointer
// - Time writes ignored unless unlocked
// - Unlock only right after key sequence
// - Enable bit writable only while unlocked
// - Ripple warning flag near rollover
// - Half-second flag; seconds write clears it
// - Output enable bit gates the pin
// - Signed trim adjusts four pulses per step
// - Config register reset by power-on only
`timescale 1ns/1ps
`include "rtc_map.svh"
module rtc_calendar_core (
  // Clock and resets
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_pin_rst,
  // Time-base pins
  input wire logic i_osc_in,
  input wire logic i_timer_clk_in,
  // Alarm event from the alarm comparator
  input wire logic i_alarm_event,
  // Avalon-MM slave
  input wire logic [4:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // Clock output pin
  output logic o_tick_out
);
  rtc_pkg::bus_req_t req;
  rtc_pkg::cfg_view_t wcfg;
  rtc_pkg::cfg_view_t cfg_rd;
  rtc_pkg::key_state_t key_state;
  rtc_pkg::key_state_t next_key;

  // Configuration, power-on reset only
  logic module_on;
  logic time_write_unlock;
  logic tick_output_on;
  logic [1:0] time_window_pointer;
  logic [7:0] trim;
  logic src_timer;
  logic out_seconds;

  // Alarm side
  logic [15:0] alarm_setup_register;
  logic [7:0] alarm_byte [6];

  // Time state
  logic [7:0] sec_v;
  logic [7:0] min_v;
  logic [7:0] hour_v;
  logic [7:0] wday_v;
  logic [7:0] day_v;
  logic [7:0] month_v;
  logic [7:0] year_v;
  logic sec_wrap;
  logic min_wrap;
  logic hour_wrap;
  logic day_wrap;
  logic month_wrap;
  logic half_pulse;
  logic second_half_flag;
  logic ripple_warning;

  assign req = {i_address, i_read, i_write, i_writedata, i_byteenable};
  assign wcfg = req.writedata[15:0];

  // Access decode
  wire logic do_acc;
  wire logic do_wr;
  wire logic do_rd;
  wire logic lane_lo;
  wire logic lane_hi;
  wire logic hit_cfg;
  wire logic hit_twin;
  wire logic hit_acfg;
  wire logic hit_awin;
  wire logic hit_key;
  wire logic hit_src;
  assign do_acc = (req.read | req.write) & o_waitrequest;
  assign do_wr = do_acc & req.write;
  assign do_rd = do_acc & req.read;
  assign lane_lo = req.byteenable[0];
  assign lane_hi = req.byteenable[1];
  assign hit_cfg = req.address == `CFG_OFS;
  assign hit_twin = req.address == `TWIN_OFS;
  assign hit_acfg = req.address == `ACFG_OFS;
  assign hit_awin = req.address == `AWIN_OFS;
  assign hit_key = req.address == `KEY_OFS;
  assign hit_src = req.address == `SRC_OFS;

  // Key sequence
  wire logic key_wr;
  wire logic key_open;
  assign key_wr = do_wr & hit_key & lane_lo;
  assign key_open = key_state == rtc_pkg::KEY_OPEN;

  always_comb begin
    next_key = key_state;
    if (do_acc) begin
      unique case (key_state)
        rtc_pkg::KEY_IDLE: begin
          if (key_wr && req.writedata[7:0] == `KEY_FIRST) begin
            next_key = rtc_pkg::KEY_GOT_FIRST;
          end
        end
        rtc_pkg::KEY_GOT_FIRST: begin
          if (key_wr && req.writedata[7:0] == `KEY_SECOND) begin
            next_key = rtc_pkg::KEY_OPEN;
          end else if (key_wr && req.writedata[7:0] == `KEY_FIRST) begin
            next_key = rtc_pkg::KEY_GOT_FIRST;
          end else begin
            next_key = rtc_pkg::KEY_IDLE;
          end
        end
        rtc_pkg::KEY_OPEN: begin
          // Window lasts exactly one further access
          next_key = rtc_pkg::KEY_IDLE;
        end
        default: begin
          next_key = rtc_pkg::KEY_IDLE;
        end
      endcase
    end
  end

  // Configuration writes
  wire logic cfg_hi_wr;
  wire logic cfg_lo_wr;
  wire logic next_unlock;
  wire logic next_on;
  assign cfg_hi_wr = do_wr & hit_cfg & lane_hi;
  assign cfg_lo_wr = do_wr & hit_cfg & lane_lo;
  assign next_unlock = cfg_hi_wr ?
                       (wcfg.time_write_unlock & (key_open | time_write_unlock)) :
                       time_write_unlock;
  assign next_on = (cfg_hi_wr & time_write_unlock) ? wcfg.module_on : module_on;

  // Time window access
  wire logic tw_hi_wr;
  wire logic tw_lo_wr;
  wire logic tw_rd;
  wire logic [1:0] next_tptr;
  assign tw_hi_wr = do_wr & hit_twin & lane_hi & time_write_unlock;
  assign tw_lo_wr = do_wr & hit_twin & lane_lo & time_write_unlock;
  assign tw_rd = do_rd & hit_twin;
  assign next_tptr = cfg_hi_wr ? wcfg.time_window_pointer :
                     ((tw_hi_wr | tw_rd) && time_window_pointer != `PTR_MS) ?
                     time_window_pointer - 2'h1 : time_window_pointer;

  wire logic ld_sec;
  wire logic ld_min;
  wire logic ld_hour;
  wire logic ld_wday;
  wire logic ld_day;
  wire logic ld_month;
  wire logic ld_year;
  assign ld_sec = tw_lo_wr & (time_window_pointer == `PTR_MS);
  assign ld_min = tw_hi_wr & (time_window_pointer == `PTR_MS);
  assign ld_hour = tw_lo_wr & (time_window_pointer == `PTR_WH);
  assign ld_wday = tw_hi_wr & (time_window_pointer == `PTR_WH);
  assign ld_day = tw_lo_wr & (time_window_pointer == `PTR_MD);
  assign ld_month = tw_hi_wr & (time_window_pointer == `PTR_MD);
  assign ld_year = tw_lo_wr & (time_window_pointer == `PTR_Y);

  // Alarm window access
  wire logic [1:0] aptr;
  wire logic aw_hi_wr;
  wire logic aw_lo_wr;
  wire logic aw_rd;
  wire logic aw_valid;
  wire logic [1:0] next_aptr;
  wire logic [2:0] a_lo_idx;
  wire logic [2:0] a_hi_idx;
  assign aptr = alarm_setup_register[`ALRM_PTR_HI:`ALRM_PTR_LO];
  assign aw_valid = aptr != `PTR_Y;
  assign aw_hi_wr = do_wr & hit_awin & lane_hi;
  assign aw_lo_wr = do_wr & hit_awin & lane_lo;
  assign aw_rd = do_rd & hit_awin;
  assign next_aptr = ((aw_hi_wr | aw_rd) && aptr != `PTR_MS) ?
                     aptr - 2'h1 : aptr;
  assign a_lo_idx = {aptr, 1'b0};
  assign a_hi_idx = {aptr, 1'b1};

  // Calendar limits
  wire logic leap;
  wire logic [7:0] day_max;
  wire logic short_month;
  assign leap = year_v[4] ?
                (year_v[3:0] == 4'h2 || year_v[3:0] == 4'h6) :
                (year_v[3:0] == 4'h0 || year_v[3:0] == 4'h4 || year_v[3:0] == 4'h8);
  assign short_month = month_v == `MON_APR || month_v == `MON_JUN ||
                       month_v == `MON_SEP || month_v == `MON_NOV;
  assign day_max = (month_v == `MON_FEB) ? (leap ? `DAY_29 : `DAY_28) :
                   short_month ? `DAY_30 : `DAY_31;

  // Count chain
  wire logic sec_step;
  assign sec_step = half_pulse & second_half_flag;

  tb_prescaler u_presc (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_run(module_on),
    .i_src_timer(src_timer),
    .i_trim(trim),
    .i_minute_edge(sec_wrap),
    .i_restart(ld_sec),
    .i_osc_in(i_osc_in),
    .i_timer_clk_in(i_timer_clk_in),
    .o_half_pulse(half_pulse),
    .o_second_half(second_half_flag),
    .o_near_rollover(ripple_warning)
  );

  bcd_unit #(.MIN_VAL(`ZERO_BCD), .RST_VAL(`ZERO_BCD)) u_sec (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_step(sec_step),
    .i_load(ld_sec),
    .i_load_val(req.writedata[7:0]),
    .i_max(`SEC_MAX),
    .o_value(sec_v),
    .o_wrap(sec_wrap)
  );

  bcd_unit #(.MIN_VAL(`ZERO_BCD), .RST_VAL(`ZERO_BCD)) u_min (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_step(sec_wrap),
    .i_load(ld_min),
    .i_load_val(req.writedata[15:8]),
    .i_max(`MIN_MAX),
    .o_value(min_v),
    .o_wrap(min_wrap)
  );

  bcd_unit #(.MIN_VAL(`ZERO_BCD), .RST_VAL(`ZERO_BCD)) u_hour (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_step(min_wrap),
    .i_load(ld_hour),
    .i_load_val(req.writedata[7:0]),
    .i_max(`HOUR_MAX),
    .o_value(hour_v),
    .o_wrap(hour_wrap)
  );

  bcd_unit #(.MIN_VAL(`ZERO_BCD), .RST_VAL(`RST_WDAY)) u_wday (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_step(hour_wrap),
    .i_load(ld_wday),
    .i_load_val(req.writedata[15:8]),
    .i_max(`WDAY_MAX),
    .o_value(wday_v),
    .o_wrap()
  );

  bcd_unit #(.MIN_VAL(`ONE_BCD), .RST_VAL(`ONE_BCD)) u_day (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_step(hour_wrap),
    .i_load(ld_day),
    .i_load_val(req.writedata[7:0]),
    .i_max(day_max),
    .o_value(day_v),
    .o_wrap(day_wrap)
  );

  bcd_unit #(.MIN_VAL(`ONE_BCD), .RST_VAL(`ONE_BCD)) u_month (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_step(day_wrap),
    .i_load(ld_month),
    .i_load_val(req.writedata[15:8]),
    .i_max(`MONTH_MAX),
    .o_value(month_v),
    .o_wrap(month_wrap)
  );

  bcd_unit #(.MIN_VAL(`ZERO_BCD), .RST_VAL(`ZERO_BCD)) u_year (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_step(month_wrap),
    .i_load(ld_year),
    .i_load_val(req.writedata[7:0]),
    .i_max(`YEAR_MAX),
    .o_value(year_v),
    .o_wrap()
  );

  // Read data selection
  wire logic [15:0] tw_rdata;
  wire logic [15:0] aw_rdata;
  wire logic [31:0] rdata;
  assign tw_rdata = (time_window_pointer == `PTR_MS) ? {min_v, sec_v} :
                    (time_window_pointer == `PTR_WH) ? {wday_v, hour_v} :
                    (time_window_pointer == `PTR_MD) ? {month_v, day_v} :
                    {8'h00, year_v};
  assign aw_rdata = aw_valid ? {alarm_byte[a_hi_idx], alarm_byte[a_lo_idx]} : 16'h0000;
  assign cfg_rd = '{module_on, 1'b0, time_write_unlock, ripple_warning,
                    second_half_flag, tick_output_on, time_window_pointer, trim};
  assign rdata = hit_cfg ? {16'h0000, cfg_rd} :
                 hit_twin ? {16'h0000, tw_rdata} :
                 hit_acfg ? {16'h0000, alarm_setup_register} :
                 hit_awin ? {16'h0000, aw_rdata} :
                 hit_src ? {30'h00000000, out_seconds, src_timer} :
                 32'h00000000;

  // Bus handshake: one wait cycle, then a single-cycle answer
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || i_pin_rst) begin
      o_waitrequest <= 1'b1;
      o_readdata <= 32'h00000000;
    end else if (do_acc) begin
      o_waitrequest <= 1'b0;
      o_readdata <= req.read ? rdata : o_readdata;
    end else begin
      o_waitrequest <= 1'b1;
    end
  end

  // Power-on reset only; pin reset leaves it
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      module_on <= 1'b0;
      time_write_unlock <= 1'b0;
      tick_output_on <= 1'b0;
      time_window_pointer <= `PTR_MS;
      trim <= 8'h00;
      src_timer <= 1'b0;
      out_seconds <= 1'b0;
    end else begin
      module_on <= next_on;
      time_write_unlock <= next_unlock;
      time_window_pointer <= next_tptr;
      if (cfg_hi_wr) begin
        tick_output_on <= wcfg.tick_output_on;
      end
      if (cfg_lo_wr) begin
        trim <= wcfg.trim;
      end
      if (do_wr && hit_src && lane_lo) begin
        src_timer <= req.writedata[`SRC_TIMER_BIT];
        out_seconds <= req.writedata[`SRC_SECONDS_BIT];
      end
    end
  end

  // Alarm setup and key state
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || i_pin_rst) begin
      alarm_setup_register <= `RST_ALARM_SETUP;
      key_state <= rtc_pkg::KEY_IDLE;
    end else begin
      key_state <= next_key;
      if (do_wr && hit_acfg) begin
        alarm_setup_register[15:8] <= lane_hi ? req.writedata[15:8] :
                                      alarm_setup_register[15:8];
        alarm_setup_register[7:0] <= lane_lo ? req.writedata[7:0] :
                                     alarm_setup_register[7:0];
      end else begin
        alarm_setup_register[`ALRM_PTR_HI:`ALRM_PTR_LO] <= next_aptr;
      end
    end
  end

  // Alarm value bytes
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      for (int i = 0; i < 6; i++) begin
        alarm_byte[i] <= `ZERO_BCD;
      end
    end else if (aw_valid) begin
      if (aw_hi_wr) begin
        alarm_byte[a_hi_idx] <= req.writedata[15:8];
      end
      if (aw_lo_wr) begin
        alarm_byte[a_lo_idx] <= req.writedata[7:0];
      end
    end
  end

  // Output pin: seconds square wave or alarm pulse
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_tick_out <= 1'b0;
    end else begin
      o_tick_out <= tick_output_on &
                    (out_seconds ? ~second_half_flag : i_alarm_event);
    end
  end
endmodule

// File: logic/tb_prescaler.sv
// Time-base edge detector, half-second prescaler and drift trim.
// Assumes time-base pins synchronous to the core clock.
`timescale 1ns/1ps
`include "rtc_map.svh"
module tb_prescaler (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // Control
  input wire logic i_run,
  input wire logic i_src_timer,
  input wire logic [7:0] i_trim,
  input wire logic i_minute_edge,
  input wire logic i_restart,
  // Time-base pins
  input wire logic i_osc_in,
  input wire logic i_timer_clk_in,
  // Status
  output logic o_half_pulse,
  output logic o_second_half,
  output logic o_near_rollover
);
  logic src_prev;
  logic [15:0] count;
  wire logic src;
  wire logic tb_edge;
  wire logic [15:0] trim_load;
  wire logic [15:0] near_mark;
  assign src = i_src_timer ? i_timer_clk_in : i_osc_in;
  assign tb_edge = src & ~src_prev;
  // Four pulses per step, sign extended
  assign trim_load = {{6{i_trim[7]}}, i_trim, 2'b00};
  assign near_mark = `HALF_LAST - `SYNC_LEAD;
  assign o_half_pulse = tb_edge & i_run & ($signed(count) >= $signed(`HALF_LAST));
  assign o_near_rollover = i_run & o_second_half & ($signed(count) >= $signed(near_mark));
  // Power-on reset only, so time survives a pin reset
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      src_prev <= 1'b0;
      count <= 16'h0000;
      o_second_half <= 1'b0;
    end else begin
      src_prev <= src;
      if (i_restart) begin
        count <= 16'h0000;
        o_second_half <= 1'b0;
      end else if (o_half_pulse) begin
        count <= i_minute_edge ? trim_load : 16'h0000;
        o_second_half <= ~o_second_half;
      end else if (tb_edge && i_run) begin
        count <= count + 16'h0001;
      end
    end
  end
endmodule

// File: verification/rtc_calendar_core_properties.sv
// Port-level checker for the clock core: bus handshake, read data, reset values, tick pin.
// Bound to rtc_calendar_core; sees its ports only, tracks tick setup from bus writes.
`timescale 1ns/1ps
`include "rtc_map.svh"
module rtc_calendar_core_checker (
  // Clock and resets
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_pin_rst,
  // Inputs
  input wire logic i_alarm_event,
  input wire logic [4:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  // Outputs
  input wire logic [31:0] o_readdata,
  input wire logic o_waitrequest,
  input wire logic o_tick_out
);
  logic tick_on;
  logic sec_sel;
  wire take_w = i_write && o_waitrequest;
  wire cfg_hit = take_w && i_byteenable[1] && (i_address == `CFG_OFS);
  wire src_hit = take_w && i_byteenable[0] && (i_address == `SRC_OFS);
  wire quiet_adr = (i_address == `KEY_OFS) || (i_address > `SRC_OFS);

  // Shadow of output enable and pin source, power-on reset only
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      tick_on <= 1'h0;
      sec_sel <= 1'h0;
    end else begin
      tick_on <= cfg_hit ? i_writedata[10] : tick_on;
      sec_sel <= src_hit ? i_writedata[`SRC_SECONDS_BIT] : sec_sel;
    end
  end

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst || i_pin_rst);

  sequence s_taken;
    (i_read || i_write) && o_waitrequest;
  endsequence
  sequence s_answer;
    !o_waitrequest ##1 o_waitrequest;
  endsequence

  a_answer_one_wait: assert property (s_taken |=> s_answer)
    else $error("bus answer not after one wait cycle");
  a_idle_no_answer: assert property (!(i_read || i_write) && o_waitrequest |=> o_waitrequest)
    else $error("answer without request");
  a_data_on_read: assert property (!$stable(o_readdata) |->
      (!o_waitrequest && i_read) || $past(i_pin_rst) || $past(i_sys_rst))
    else $error("read data changed outside a read answer");
  a_upper_zero: assert property (!o_waitrequest |-> o_readdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_key_reads_zero: assert property (!o_waitrequest && i_read && quiet_adr |->
      o_readdata == 32'h0000_0000)
    else $error("key or unmapped read not zero");
  a_sys_reset_quiet: assert property (disable iff (1'h0) i_sys_rst |=>
      o_waitrequest && o_readdata == 32'h0000_0000 && !o_tick_out)
    else $error("outputs not idle after power-on reset");
  a_pin_reset_quiet: assert property (disable iff (i_sys_rst) i_pin_rst |=>
      o_waitrequest && o_readdata == 32'h0000_0000)
    else $error("bus not idle after pin reset");
  a_tick_off: assert property (!tick_on && !$past(tick_on) |-> !o_tick_out)
    else $error("tick pin active while output disabled");
  a_tick_alarm_hi: assert property ((tick_on && !sec_sel && i_alarm_event)[*3] |-> o_tick_out)
    else $error("alarm not passed to tick pin");
  a_tick_alarm_lo: assert property ((tick_on && !sec_sel && !i_alarm_event)[*3] |-> !o_tick_out)
    else $error("tick pin high without alarm");
endmodule

bind rtc_calendar_core rtc_calendar_core_checker rtc_calendar_core_checker_inst (
  .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_pin_rst(i_pin_rst),
  .i_alarm_event(i_alarm_event), .i_address(i_address), .i_read(i_read),
  .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
  .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_tick_out(o_tick_out)
);

// File: verification/rtc_calendar_core_tb.sv
// Self-checking bench for the clock core: register bus, calendar, trim and tick pin.
// Drives every port itself; the chosen time base pin pulses high once per two core cycles.
`timescale 1ns/1ps
`include "rtc_map.svh"
module rtc_calendar_core_tb;
  logic i_core_clk = 1'h0;
  logic i_sys_rst = 1'h1;
  logic i_pin_rst = 1'h0;
  logic i_osc_in = 1'h0;
  logic i_timer_clk_in = 1'h0;
  logic i_alarm_event = 1'h0;
  logic [4:0] i_address = 5'h00;
  logic i_read = 1'h0;
  logic i_write = 1'h0;
  logic [31:0] i_writedata = 32'h0;
  logic [3:0] i_byteenable = 4'h0;
  logic [31:0] o_readdata;
  logic o_waitrequest;
  logic o_tick_out;
  int err_count = 0;
  int checked = 0;
  logic [31:0] seed;

  initial begin
    forever #25 i_core_clk = ~i_core_clk;
  end

  rtc_calendar_core rtc_calendar_core_inst (
    .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_pin_rst(i_pin_rst),
    .i_osc_in(i_osc_in), .i_timer_clk_in(i_timer_clk_in), .i_alarm_event(i_alarm_event),
    .i_address(i_address), .i_read(i_read), .i_write(i_write),
    .i_writedata(i_writedata), .i_byteenable(i_byteenable), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .o_tick_out(o_tick_out)
  );

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic done(input string name);
    $display("Test %s done", name);
  endtask

  // One bus cycle; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int n;
    i_address <= a;
    i_writedata <= {16'h0000, d};
    i_byteenable <= be;
    i_read <= ~wr;
    i_write <= wr;
    n = 0;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (o_waitrequest !== 1'h0 && n < 20);
    q = o_readdata;
    i_read <= 1'h0;
    i_write <= 1'h0;
    if (n >= 20) begin
      err_count++;
      report_and_stop();
    end
    @(posedge i_core_clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic [3:0] be);
    logic [31:0] q;
    bus(1'h1, a, d, be, q);
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    logic [31:0] q;
    bus(1'h0, a, 16'h0000, 4'h3, q);
    chk($sformatf("reg %h", a), q, {16'h0000, e});
  endtask

  task automatic unlock();
    wr(`KEY_OFS, {8'h00, `KEY_FIRST}, 4'h1);
    wr(`KEY_OFS, {8'h00, `KEY_SECOND}, 4'h1);
  endtask

  task automatic tk(input logic e);
    repeat (3) @(posedge i_core_clk);
    chk("tick", {31'h0, o_tick_out}, {31'h0, e});
  endtask

  // Rising edges on the oscillator pin or the timer pin
  task automatic edges(input int n, input logic tmr);
    repeat (n) begin
      i_osc_in <= ~tmr;
      i_timer_clk_in <= tmr;
      @(posedge i_core_clk);
      i_osc_in <= 1'h0;
      i_timer_clk_in <= 1'h0;
      @(posedge i_core_clk);
    end
    repeat (4) @(posedge i_core_clk);
  endtask

  // Month and day after 28 February of a BCD year
  function automatic logic [15:0] feb_next(input logic [7:0] y);
    logic lp;
    lp = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6) : (y[3:0] % 4 == 0);
    return lp ? 16'h0229 : 16'h0301;
  endfunction

  initial begin
    logic [15:0] al [3];
    logic [4:0] adr [3];
    adr = '{`KEY_OFS, 5'h18, 5'h1C};
    seed = $urandom(32'hCBBB);
    repeat (12) @(posedge i_core_clk);
    i_sys_rst <= 1'h0;
    @(posedge i_core_clk);
    rd(`CFG_OFS, 16'h0000);
    i_alarm_event <= 1'h1;
    tk(1'h0);
    i_alarm_event <= 1'h0;
    done("reset");
    wr(`CFG_OFS, 16'h8300, 4'h3);
    rd(`CFG_OFS, 16'h0300);
    wr(`TWIN_OFS, 16'h1234, 4'h3);
    rd(`CFG_OFS, 16'h0300);
    rd(`TWIN_OFS, 16'h0000);
    rd(`TWIN_OFS, 16'h0101);
    rd(`TWIN_OFS, 16'h0600);
    rd(`CFG_OFS, 16'h0000);
    done("lock");
    unlock();
    rd(`KEY_OFS, 16'h0000);
    wr(`CFG_OFS, 16'h2000, 4'h3);
    rd(`CFG_OFS, 16'h0000);
    unlock();
    wr(`CFG_OFS, 16'h237F, 4'h3);
    rd(`CFG_OFS, 16'h237F);
    wr(`TWIN_OFS, 16'h0024, 4'h3);
    wr(`TWIN_OFS, 16'h0228, 4'h3);
    wr(`TWIN_OFS, 16'h0323, 4'h3);
    wr(`TWIN_OFS, 16'h5959, 4'h3);
    rd(`CFG_OFS, 16'h207F);
    done("key");
    for (int i = 0; i < 3; i++) al[i] = 16'($urandom);
    wr(`ACFG_OFS, 16'h0200, 4'h3);
    for (int i = 2; i >= 0; i--) wr(`AWIN_OFS, al[i], 4'h3);
    rd(`ACFG_OFS, 16'h0000);
    wr(`ACFG_OFS, 16'h8300, 4'h3);
    rd(`AWIN_OFS, 16'h0000);
    for (int i = 2; i >= 0; i--) rd(`AWIN_OFS, al[i]);
    rd(`AWIN_OFS, al[0]);
    rd(`ACFG_OFS, 16'h8000);
    done("alarm");
    foreach (adr[i]) begin
      wr(adr[i], 16'($urandom), 4'h3);
      rd(adr[i], 16'h0000);
    end
    done("unmapped");
    wr(`CFG_OFS, 16'hA77F, 4'h3);
    rd(`TWIN_OFS, 16'h0024);
    rd(`TWIN_OFS, 16'h0228);
    rd(`TWIN_OFS, 16'h0323);
    rd(`TWIN_OFS, 16'h5959);
    i_alarm_event <= 1'h1;
    tk(1'h1);
    i_alarm_event <= 1'h0;
    tk(1'h0);
    wr(`SRC_OFS, 16'h0002, 4'h1);
    tk(1'h1);
    done("tick");
    edges(100, 1'h0);
    i_pin_rst <= 1'h1;
    edges(20, 1'h0);
    i_pin_rst <= 1'h0;
    edges(1, 1'h0);
    rd(`CFG_OFS, 16'hA47F);
    rd(`ACFG_OFS, 16'h0000);
    rd(`SRC_OFS, 16'h0002);
    done("pinreset");
    edges(16262, 1'h0);
    rd(`CFG_OFS, 16'hA47F);
    edges(1, 1'h0);
    rd(`CFG_OFS, 16'hAC7F);
    tk(1'h0);
    edges(16350, 1'h0);
    rd(`CFG_OFS, 16'hAC7F);
    edges(1, 1'h0);
    rd(`CFG_OFS, 16'hBC7F);
    edges(33, 1'h0);
    rd(`CFG_OFS, 16'hA47F);
    rd(`TWIN_OFS, 16'h0000);
    wr(`CFG_OFS, 16'hA77F, 4'h3);
    rd(`TWIN_OFS, 16'h0024);
    rd(`TWIN_OFS, feb_next(8'h24));
    rd(`TWIN_OFS, 16'h0400);
    rd(`TWIN_OFS, 16'h0000);
    done("rollover");
    wr(`SRC_OFS, 16'h0003, 4'h1);
    edges(16384 - 4 * 127 - 1, 1'h1);
    rd(`CFG_OFS, 16'hA47F);
    edges(1, 1'h1);
    rd(`CFG_OFS, 16'hAC7F);
    wr(`TWIN_OFS, 16'h0030, 4'h1);
    rd(`CFG_OFS, 16'hA47F);
    wr(`CFG_OFS, 16'h847F, 4'h3);
    wr(`TWIN_OFS, 16'h1111, 4'h3);
    rd(`TWIN_OFS, 16'h0030);
    rd(`CFG_OFS, 16'h847F);
    done("trim");
    report_and_stop();
  end
endmodule
